/* File: sdcbf_pkg.sv */
// Package: command codes, bank states, timing counts and pin groups
package sdcbf_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 40000;
   localparam int PRECHARGE_PERIOD_PS = 15000;
   localparam int ACTIVATE_TO_COLUMN_DELAY_PS = 15000;
   localparam int REFRESH_CYCLE_TIME_PS = 127500;
   localparam int WRITE_RECOVERY_PS = 15000;
   localparam int SELF_REFRESH_EXIT_DELAY_PS = 137500;
   localparam int MODE_REGISTER_DELAY_CK = 2;
   localparam int BURST_LENGTH = 4;

   function automatic int min_cycles(input int ps);
      int c;
      c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int PRECHARGE_PERIOD_CK = min_cycles(PRECHARGE_PERIOD_PS);
   localparam int ACTIVATE_TO_COLUMN_DELAY_CK = min_cycles(ACTIVATE_TO_COLUMN_DELAY_PS);
   localparam int REFRESH_CYCLE_TIME_CK = min_cycles(REFRESH_CYCLE_TIME_PS);
   localparam int WRITE_RECOVERY_CK = min_cycles(WRITE_RECOVERY_PS);
   localparam int SELF_REFRESH_EXIT_DELAY_CK = min_cycles(SELF_REFRESH_EXIT_DELAY_PS);
   localparam int BURST_CK = BURST_LENGTH / 2;

   // ------------------------------------------------------------
   // Widths and fields
   // ------------------------------------------------------------
   localparam int CNT_W = 4;
   localparam int NUM_BANKS = 8;
   localparam int BA_W = 3;
   localparam int ADDR_W = 14;
   localparam int AUTO_PRECHARGE_BIT = 10;
   localparam int COL_BITS_DEFAULT = 10;
   localparam logic [BA_W-1:0] BA_LOW_MASK = 3'h3;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      CMD_DESELECT, CMD_NOP, CMD_MODE_LOAD, CMD_REFRESH, CMD_SR_ENTRY,
      CMD_PRECHARGE, CMD_PRECHARGE_ALL, CMD_ACTIVATE, CMD_WRITE, CMD_WRITE_AP,
      CMD_READ, CMD_READ_AP, CMD_PD_ENTRY, CMD_CKE_EXIT, CMD_ILLEGAL
   } sdcbf_cmd_e;

   typedef enum logic [2:0] {
      BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READING, BK_WRITING,
      BK_READ_AP, BK_WRITE_AP, BK_PRECHARGING
   } sdcbf_bank_e;

   typedef enum logic [1:0] {PWR_ON, PWR_DOWN, PWR_SELF_REFRESH} sdcbf_pwr_e;

   typedef struct packed {
      logic cke;
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
   } sdcbf_pins_s;

   typedef struct packed {
      logic [BA_W-1:0] ba;
      logic [ADDR_W-1:0] a;
   } sdcbf_addr_s;

   typedef struct packed {
      sdcbf_cmd_e cmd;
      logic [BA_W-1:0] bank;
      logic [ADDR_W-1:0] col;
      logic auto_pre;
   } sdcbf_dec_s;

   typedef struct packed {
      sdcbf_bank_e st;
      logic [CNT_W-1:0] cnt;
   } sdcbf_bank_s;

   typedef struct packed {
      sdcbf_pins_s sync1;
      sdcbf_pins_s sync2;
      sdcbf_addr_s addr1;
      sdcbf_addr_s addr2;
      logic odt1;
      logic odt2;
      logic ckep;
      sdcbf_pwr_e pwr;
      logic [CNT_W-1:0] gcnt;
      logic [CNT_W-1:0] xcnt;
      sdcbf_cmd_e cmd;
      logic strobe;
      logic mode_load;
      logic [BA_W-1:0] mode_sel;
      logic [ADDR_W-1:0] mode_op;
      logic [BA_W-1:0] bank;
      logic [ADDR_W-1:0] col;
      logic auto_pre;
      logic illegal;
      logic odt_en;
   } sdcbf_top_s;
endpackage

/* File: sdcbf_cmd_decode.sv */
// Combinational decoder from sampled strobe levels to a command code
module sdcbf_cmd_decode
   import sdcbf_pkg::*;
#(
   parameter bit DENSITY_GE_1GB = 1'b1,
   parameter int COL_BITS = COL_BITS_DEFAULT
) (
   input wire sdcbf_pins_s pins,
   input wire logic cke_prev,
   input wire sdcbf_addr_s addr,
   output sdcbf_dec_s dec
);
   localparam logic [ADDR_W-1:0] COL_MASK = ADDR_W'((1 << COL_BITS) - 1);

   logic [2:0] sel;
   logic nop_like;

   always_comb begin
      sel = {pins.ras_n, pins.cas_n, pins.we_n};
      nop_like = pins.cs_n || (sel == 3'h7);
      dec.cmd = CMD_ILLEGAL;
      dec.bank = DENSITY_GE_1GB ? addr.ba : (addr.ba & BA_LOW_MASK); // [RL8]
      dec.col = addr.a & COL_MASK; // [RL9]
      dec.auto_pre = addr.a[AUTO_PRECHARGE_BIT]; // [RL6]
      if (!cke_prev) begin
         // Strobes are only looked at when clock enable rises
         dec.cmd = pins.cke ? (nop_like ? CMD_CKE_EXIT : CMD_ILLEGAL) : CMD_NOP;
      end else if (nop_like) begin
         if (!pins.cke) begin
            dec.cmd = CMD_PD_ENTRY; // [RL5]
         end else begin
            dec.cmd = pins.cs_n ? CMD_DESELECT : CMD_NOP; // [RL2]
         end
      end else if (!pins.cke) begin
         dec.cmd = (sel == 3'h1) ? CMD_SR_ENTRY : CMD_ILLEGAL; // [RL4]
      end else begin
         case (sel) // [RL1]
            3'h0: dec.cmd = CMD_MODE_LOAD; // [RL3]
            3'h1: dec.cmd = CMD_REFRESH;
            3'h2: dec.cmd = dec.auto_pre ? CMD_PRECHARGE_ALL : CMD_PRECHARGE; // [RL6]
            3'h3: dec.cmd = CMD_ACTIVATE;
            3'h4: dec.cmd = dec.auto_pre ? CMD_WRITE_AP : CMD_WRITE; // [RL6]
            3'h5: dec.cmd = dec.auto_pre ? CMD_READ_AP : CMD_READ;
            default: dec.cmd = CMD_ILLEGAL;
         endcase
      end
   end
endmodule // sdcbf_cmd_decode

/* File: sdcbf_bank.sv */
// One bank: state and remaining cycles of its timed interval
module sdcbf_bank
   import sdcbf_pkg::*;
#(
   parameter int RP = PRECHARGE_PERIOD_CK,
   parameter int RCD = ACTIVATE_TO_COLUMN_DELAY_CK,
   parameter int WR = WRITE_RECOVERY_CK,
   parameter int BURST = BURST_CK
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic ce,
   input wire sdcbf_cmd_e cmd,
   input wire logic hit,
   output sdcbf_bank_e state,
   output logic illegal
);
   localparam int RCD_A = RCD;
   localparam int RP_A = RP;
   localparam int RDAP_M1 = BURST + RP - 1;

   sdcbf_bank_s r;
   sdcbf_bank_s n;
   logic last;
   logic busy;

   // Intervals of one cycle finish at the registering edge itself
   function automatic sdcbf_bank_s start(input sdcbf_bank_e timed,
                                         input sdcbf_bank_e done, input int len);
      sdcbf_bank_s s;
      s.st = (len <= 1) ? done : timed;
      s.cnt = (len <= 1) ? '0 : CNT_W'(len - 1);
      return s;
   endfunction

   always_comb begin
      n = r;
      illegal = 1'b0;
      last = (r.cnt == CNT_W'(1));
      busy = 1'b0;
      case (r.st)
         BK_IDLE: begin
            if (hit) begin
               if (cmd == CMD_ACTIVATE) begin
                  n = start(BK_ACTIVATING, BK_ACTIVE, RCD); // [RL16]
               end else if (!(cmd inside {CMD_PRECHARGE, CMD_PRECHARGE_ALL})) begin
                  illegal = 1'b1; // [RL22]
               end
            end
         end
         BK_ACTIVATING, BK_PRECHARGING, BK_READ_AP, BK_WRITE_AP: begin
            illegal = hit; // [RL15]
            if (last) begin
               n.st = (r.st == BK_ACTIVATING) ? BK_ACTIVE : BK_IDLE; // [RL12] [RL17] [RL18]
               n.cnt = '0;
            end else begin
               n.cnt = r.cnt - CNT_W'(1); // [RL23]
            end
         end
         BK_ACTIVE, BK_READING, BK_WRITING: begin
            busy = (r.st != BK_ACTIVE) && !last;
            if (r.st != BK_ACTIVE) begin
               n.st = last ? BK_ACTIVE : r.st;
               n.cnt = last ? '0 : r.cnt - CNT_W'(1);
            end
            if (hit) begin
               // Burst of four runs to its end before the bank takes more
               if (busy || cmd == CMD_ACTIVATE) begin
                  illegal = 1'b1; // [RL10] [RL14]
               end else begin
                  case (cmd)
                     CMD_READ: n = '{BK_READING, CNT_W'(BURST)};
                     CMD_WRITE: n = '{BK_WRITING, CNT_W'(BURST)};
                     CMD_READ_AP: n = start(BK_READ_AP, BK_IDLE, BURST + RP); // [RL18]
                     CMD_WRITE_AP: n = start(BK_WRITE_AP, BK_IDLE, BURST + WR + RP);
                     CMD_PRECHARGE, CMD_PRECHARGE_ALL:
                        n = start(BK_PRECHARGING, BK_IDLE, RP); // [RL17] [RL21]
                     default: illegal = 1'b1;
                  endcase
               end
            end
         end
         default: n = '{BK_IDLE, '0};
      endcase
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         r <= '{BK_IDLE, '0};
      end else if (ce) begin
         r <= n;
      end
   end

   assign state = r.st;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   act_to_active_a: assert property (@(posedge clock iff ce) disable iff (!resetn) // [RL16]
      hit && cmd == CMD_ACTIVATE && r.st == BK_IDLE |-> ##RCD_A state == BK_ACTIVE)
      else $error("bank not row-active after activate delay");
   pre_to_idle_a: assert property (@(posedge clock iff ce) disable iff (!resetn) // [RL17]
      hit && cmd inside {CMD_PRECHARGE, CMD_PRECHARGE_ALL} && r.st == BK_ACTIVE
      |-> ##RP_A state == BK_IDLE)
      else $error("bank not idle after precharge period");
   rdap_to_idle_a: assert property (@(posedge clock iff ce) disable iff (!resetn) // [RL18]
      hit && cmd == CMD_READ_AP && r.st == BK_ACTIVE
      |-> ##1 state == BK_READ_AP ##RDAP_M1 state == BK_IDLE)
      else $error("auto precharge read did not end idle on time");
   burst_guard_a: assert property (@(posedge clock iff ce) disable iff (!resetn) // [RL10]
      hit && r.st inside {BK_READING, BK_WRITING} && r.cnt > CNT_W'(1) |-> illegal)
      else $error("burst interrupted without flag");
endmodule // sdcbf_bank

/* File: sdcbf_command_fsm.sv */
// Top: pin sampling, command decode, power modes and per-bank tracking
// What this block does
// RL1: Commands decode from chip select, strobes and clock enable at rising edge.
// RL2: Chip select high or NOP encoding starts nothing; running intervals continue.
// RL3: All strobes low with clock enable high loads a mode register.
// RL4: Refresh encoding with clock enable falling enters self refresh; rising exits.
// RL5: Clock enable low with NOP enters power-down; high exits; no refresh there.
// RL6: Address bit ten selects auto precharge, or all-bank precharge.
// RL7: Termination input never alters decoding; termination is off in self refresh.
// RL8: Third bank address bit counts only for one-gigabit or larger densities.
// RL9: Column address bits above the configured width are ignored.
// RL10: Bursts of four are never interrupted by a later command.
// RL11: Bank legality applies only after two high clock-enable samples and exit delay.
// RL12: Idle after precharge; row-active after activate delay with no burst.
// RL13: Refresh and mode load only while every bank is idle.
// RL14: Row-active banks take read, write, precharge; write waits for read end.
// RL15: A bank in a timed interval takes no command of its own.
// RL16: Activate makes the bank row-active once the activate delay passes.
// RL17: Single-bank precharge returns the bank idle after the precharge period.
// RL18: Auto precharge access keeps the bank busy until idle after precharge.
// RL19: Refresh, mode load and precharge-all intervals accept only deselect or NOP.
// RL20: All banks idle after refresh cycle time or mode register delay.
// RL21: Precharge-all returns every bank idle after the precharge period.
// RL22: Precharge of several banks needs each valid; other sequences are illegal.
// RL23: Counters track every bank state and its remaining interval cycles.
module sdcbf_command_fsm
   import sdcbf_pkg::*;
#(
   parameter bit DENSITY_GE_1GB = 1'b1,
   parameter int COL_BITS = COL_BITS_DEFAULT,
   parameter int BANKS = NUM_BANKS
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic ce,
   input wire sdcbf_pins_s pins,
   input wire sdcbf_addr_s addr,
   input wire logic termination_control,
   output sdcbf_cmd_e cmd_code,
   output logic cmd_strobe,
   output logic [BA_W-1:0] cmd_bank,
   output logic [ADDR_W-1:0] col_addr,
   output logic auto_precharge_bit,
   output logic mode_load,
   output logic [BA_W-1:0] mode_select,
   output logic [ADDR_W-1:0] mode_opcode,
   output logic [BANKS-1:0] bank_idle,
   output logic [BANKS-1:0] bank_open,
   output logic all_idle,
   output logic power_down,
   output logic self_refresh,
   output logic termination_enable,
   output logic illegal
);
   // ------------------------------------------------------------
   // Interval lengths
   // ------------------------------------------------------------
   // Global counter holds cycles still to wait after the taking edge
   localparam logic [CNT_W-1:0] RFC_LOAD = CNT_W'(REFRESH_CYCLE_TIME_CK - 1);
   localparam logic [CNT_W-1:0] MRD_LOAD = CNT_W'(MODE_REGISTER_DELAY_CK - 1);
   localparam logic [CNT_W-1:0] RP_LOAD = CNT_W'(PRECHARGE_PERIOD_CK - 1);
   localparam logic [CNT_W-1:0] XSNR_LOAD = CNT_W'(SELF_REFRESH_EXIT_DELAY_CK - 1);
   localparam int RFC_M1 = REFRESH_CYCLE_TIME_CK - 1;
   localparam int MRD_M1 = MODE_REGISTER_DELAY_CK - 1;

   sdcbf_top_s r;
   sdcbf_top_s n;
   sdcbf_dec_s dec;
   sdcbf_bank_e bank_state [BANKS];
   logic [BANKS-1:0] bank_hit;
   logic [BANKS-1:0] bank_bad;
   logic bank_go;
   logic window;
   logic quiet;
   logic all_idle_w;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   // The second sampling stage and the delayed clock-enable sample feed the decoder
   sdcbf_cmd_decode #(
      .DENSITY_GE_1GB(DENSITY_GE_1GB),
      .COL_BITS(COL_BITS)
   ) u_decode (
      .pins(r.sync2),
      .cke_prev(r.ckep),
      .addr(r.addr2),
      .dec(dec)
   );

   // Both clock-enable samples high and exit delay gone
   assign window = r.ckep && r.sync2.cke && (r.xcnt == '0) && (r.pwr == PWR_ON); // [RL11]
   assign quiet = dec.cmd inside {CMD_DESELECT, CMD_NOP}; // [RL2]
   assign bank_go = window && (r.gcnt == '0) && (dec.cmd inside {CMD_PRECHARGE,
      CMD_PRECHARGE_ALL, CMD_ACTIVATE, CMD_WRITE, CMD_WRITE_AP, CMD_READ, CMD_READ_AP});

   // ------------------------------------------------------------
   // Banks
   // ------------------------------------------------------------
   for (genvar i = 0; i < BANKS; i++) begin : g_bank
      assign bank_hit[i] = bank_go &&
         (dec.cmd == CMD_PRECHARGE_ALL || dec.bank == BA_W'(i)); // [RL21]
      sdcbf_bank u_bank (
         .clock(clock),
         .resetn(resetn),
         .ce(ce),
         .cmd(dec.cmd),
         .hit(bank_hit[i]),
         .state(bank_state[i]),
         .illegal(bank_bad[i])
      );
      assign bank_idle[i] = (bank_state[i] == BK_IDLE);
      assign bank_open[i] = (bank_state[i] == BK_ACTIVE);
   end

   assign all_idle_w = (&bank_idle) && (r.gcnt == '0); // [RL20]

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      n = r;
      n.sync1 = pins;
      n.sync2 = r.sync1;
      n.addr1 = addr;
      n.addr2 = r.addr1;
      n.odt1 = termination_control;
      n.odt2 = r.odt1;
      n.ckep = r.sync2.cke;
      n.strobe = 1'b0;
      n.mode_load = 1'b0;
      n.illegal = 1'b0;
      if (r.gcnt != '0) begin
         n.gcnt = r.gcnt - CNT_W'(1); // [RL23]
      end
      if (r.xcnt != '0) begin
         n.xcnt = r.xcnt - CNT_W'(1);
      end
      case (r.pwr)
         PWR_ON: begin
            if (r.ckep && !r.sync2.cke) begin
               if (dec.cmd == CMD_SR_ENTRY && all_idle_w) begin
                  n.pwr = PWR_SELF_REFRESH; // [RL4]
               end else if (dec.cmd == CMD_PD_ENTRY && r.gcnt == '0) begin
                  n.pwr = PWR_DOWN; // [RL5]
               end else begin
                  n.illegal = 1'b1;
               end
            end else if (window && !quiet) begin
               if (dec.cmd == CMD_ILLEGAL || r.gcnt != '0) begin
                  n.illegal = 1'b1; // [RL19] [RL22]
               end else if (dec.cmd inside {CMD_REFRESH, CMD_MODE_LOAD} && !all_idle_w) begin
                  n.illegal = 1'b1; // [RL13]
               end else if (|bank_bad) begin
                  n.illegal = 1'b1; // [RL14] [RL15] [RL22]
               end else begin
                  n.strobe = 1'b1; // [RL1]
                  n.cmd = dec.cmd;
                  n.bank = dec.bank;
                  n.col = dec.col;
                  n.auto_pre = dec.auto_pre; // [RL6]
                  case (dec.cmd)
                     CMD_REFRESH: n.gcnt = RFC_LOAD; // [RL20]
                     CMD_MODE_LOAD: begin
                        n.gcnt = MRD_LOAD; // [RL20]
                        n.mode_load = 1'b1; // [RL3]
                        n.mode_sel = dec.bank;
                        n.mode_op = r.addr2.a;
                     end
                     CMD_PRECHARGE_ALL: n.gcnt = RP_LOAD; // [RL19]
                     default: n.gcnt = r.gcnt;
                  endcase
               end
            end
         end
         PWR_DOWN: begin
            // Banks keep their state; the controller owns the refresh budget
            if (r.sync2.cke) begin
               n.pwr = PWR_ON; // [RL5]
               n.illegal = (dec.cmd != CMD_CKE_EXIT);
            end
         end
         PWR_SELF_REFRESH: begin
            // Exit on the level alone, whatever the strobes show
            if (r.sync2.cke) begin
               n.pwr = PWR_ON; // [RL4]
               n.xcnt = XSNR_LOAD; // [RL11]
            end
         end
         default: n.pwr = PWR_ON;
      endcase
      n.odt_en = r.odt2 && (n.pwr != PWR_SELF_REFRESH); // [RL7]
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!resetn) begin
         r <= '0;
      end else if (ce) begin
         r <= n;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign cmd_code = r.cmd;
   assign cmd_strobe = r.strobe;
   assign cmd_bank = r.bank;
   assign col_addr = r.col;
   assign auto_precharge_bit = r.auto_pre;
   assign mode_load = r.mode_load;
   assign mode_select = r.mode_sel;
   assign mode_opcode = r.mode_op;
   assign all_idle = all_idle_w;
   assign power_down = (r.pwr == PWR_DOWN);
   assign self_refresh = (r.pwr == PWR_SELF_REFRESH);
   assign termination_enable = r.odt_en;
   assign illegal = r.illegal;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   refresh_idle_a: assert property (@(posedge clock iff ce) disable iff (!resetn) // [RL20]
      cmd_strobe && cmd_code == CMD_REFRESH |-> ##RFC_M1 all_idle)
      else $error("banks not idle after refresh cycle time");
   mode_idle_a: assert property (@(posedge clock iff ce) disable iff (!resetn) // [RL20]
      mode_load |-> ##MRD_M1 all_idle)
      else $error("banks not idle after mode register delay");
   mode_cmd_a: assert property (@(posedge clock iff ce) disable iff (!resetn) // [RL3]
      mode_load |-> cmd_strobe && cmd_code == CMD_MODE_LOAD && mode_select == cmd_bank)
      else $error("mode load strobe without mode load command");
   sr_term_off_a: assert property (@(posedge clock iff ce) disable iff (!resetn) // [RL7]
      self_refresh |-> !termination_enable)
      else $error("termination enabled in self refresh");
   sr_exit_a: assert property (@(posedge clock iff ce) disable iff (!resetn) // [RL4]
      self_refresh && r.sync2.cke |=> !self_refresh ##1 !cmd_strobe)
      else $error("self refresh exit missed or command too early");
   pd_no_cmd_a: assert property (@(posedge clock iff ce) disable iff (!resetn) // [RL5]
      power_down |=> !cmd_strobe)
      else $error("command taken during power-down");
   busy_refused_a: assert property (@(posedge clock iff ce) disable iff (!resetn) // [RL19]
      window && !quiet && r.gcnt != '0 |=> illegal && !cmd_strobe)
      else $error("command taken inside global interval");
   refresh_needs_idle_a: assert property (@(posedge clock iff ce) disable iff (!resetn) // [RL13]
      cmd_strobe && cmd_code inside {CMD_REFRESH, CMD_MODE_LOAD} |-> $past(all_idle_w))
      else $error("refresh or mode load taken with busy bank");
endmodule // sdcbf_command_fsm

/* File: sdcbf_ctl_model.sv */
// Controller model: puts commands on the strobes and drives the address
module sdcbf_ctl_model
   import sdcbf_pkg::*;
(
   input wire logic go,
   input wire sdcbf_cmd_e cmd,
   input wire logic [BA_W-1:0] ba,
   input wire logic [ADDR_W-1:0] a,
   input wire logic cke,
   output sdcbf_pins_s pins,
   output sdcbf_addr_s addr
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Encoding
   // ------------------------------------------------------------
   logic [3:0] s;
   sdcbf_addr_s cur;
   always_comb begin
      s = 4'h7;
      cur = {ba, a};
      if (go) begin
         case (cmd)
            CMD_DESELECT: s = 4'h8; // Strobes low behind a high select
            CMD_MODE_LOAD: s = 4'h0;
            CMD_REFRESH, CMD_SR_ENTRY: s = 4'h1;
            CMD_PRECHARGE, CMD_PRECHARGE_ALL: s = 4'h2;
            CMD_ACTIVATE: s = 4'h3;
            CMD_WRITE, CMD_WRITE_AP: s = 4'h4;
            CMD_READ, CMD_READ_AP: s = 4'h5;
            default: s = 4'h7;
         endcase
         if (cmd inside {CMD_PRECHARGE, CMD_READ, CMD_WRITE}) begin
            cur.a[AUTO_PRECHARGE_BIT] = 1'b0;
         end
         if (cmd inside {CMD_PRECHARGE_ALL, CMD_READ_AP, CMD_WRITE_AP}) begin
            cur.a[AUTO_PRECHARGE_BIT] = 1'b1;
         end
      end
   end
   assign pins = {cke, s};
   // Address moves with the strobes; the block syncs both alike
   assign addr = cur;
endmodule // sdcbf_ctl_model

/* File: sdcbf_command_fsm_tb_top.sv */
// Testbench: command decode, bank tracking and power modes
module sdcbf_command_fsm_tb_top import sdcbf_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0, resetn = 1'b0, go = 1'b0, cke = 1'b1, term = 1'b0;
   sdcbf_cmd_e cmd = CMD_NOP;
   logic [BA_W-1:0] ba = '0;
   logic [ADDR_W-1:0] a = '0;
   sdcbf_pins_s pins;
   sdcbf_addr_s addr;
   sdcbf_cmd_e cmd_code;
   logic cmd_strobe, auto_precharge_bit, mode_load, all_idle, power_down, self_refresh;
   logic termination_enable, illegal;
   logic [BA_W-1:0] cmd_bank, mode_select;
   logic [ADDR_W-1:0] col_addr, mode_opcode;
   logic [NUM_BANKS-1:0] bank_idle, bank_open;
   int fail_count = 0, total_checks = 0;
   always #20 clock = ~clock;
   sdcbf_ctl_model ctl_u (.go(go), .cmd(cmd), .ba(ba), .a(a), .cke(cke),
      .pins(pins), .addr(addr));
   sdcbf_command_fsm dut_u (.clock(clock), .resetn(resetn), .ce(1'b1), .pins(pins),
      .addr(addr), .termination_control(term), .cmd_code(cmd_code), .cmd_strobe(cmd_strobe),
      .cmd_bank(cmd_bank), .col_addr(col_addr), .auto_precharge_bit(auto_precharge_bit),
      .mode_load(mode_load), .mode_select(mode_select), .mode_opcode(mode_opcode),
      .bank_idle(bank_idle), .bank_open(bank_open), .all_idle(all_idle),
      .power_down(power_down), .self_refresh(self_refresh),
      .termination_enable(termination_enable), .illegal(illegal));
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input bit ok, input string msg);
      total_checks++;
      if (!ok) begin
         fail_count++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask
   // Holds go for one cycle; the caller lowers it, so back-to-back sends never glitch
   task automatic send(input sdcbf_cmd_e c, input logic [BA_W-1:0] b, input logic [13:0] x);
      go = 1'b1;
      cmd = c;
      ba = b;
      a = x;
      @(negedge clock);
   endtask
   task automatic resp(input bit ill, input sdcbf_cmd_e c);
      int n;
      go = 1'b0;
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (!(cmd_strobe === 1'b1 || illegal === 1'b1) && n < 8);
      check(illegal === ill && cmd_strobe === !ill && (ill || cmd_code === c), "command response");
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_open_read_close();
      send(CMD_ACTIVATE, 3'h3, 14'h0);
      resp(1'b0, CMD_ACTIVATE);
      check(bank_open === 8'h08 && bank_idle[3] === 1'b0, "bank not open");
      send(CMD_READ, 3'h3, 14'h3bff);
      send(CMD_PRECHARGE, 3'h3, 14'h0); // Lands in the burst
      resp(1'b0, CMD_READ);
      check(col_addr === 14'h3ff && auto_precharge_bit === 1'b0, "read fields");
      resp(1'b1, CMD_PRECHARGE);
      send(CMD_PRECHARGE, 3'h3, 14'h0);
      resp(1'b0, CMD_PRECHARGE);
      repeat (3) @(negedge clock);
      check(bank_idle === 8'hff && bank_open === 8'h00, "bank not idle");
   endtask
   task automatic t_auto_precharge();
      send(CMD_ACTIVATE, 3'h4, 14'h0);
      resp(1'b0, CMD_ACTIVATE);
      check(bank_open === 8'h10, "upper bank bit");
      send(CMD_READ_AP, 3'h4, 14'h0); // Follow-up read lands inside the burst
      send(CMD_READ, 3'h4, 14'h0);
      resp(1'b0, CMD_READ_AP);
      check(auto_precharge_bit === 1'b1 && cmd_bank === 3'h4, "auto precharge flag");
      resp(1'b1, CMD_READ);
      repeat (6) @(negedge clock);
      check(bank_idle === 8'hff, "auto precharge end");
   endtask
   task automatic t_refresh();
      send(CMD_REFRESH, 3'h0, 14'h0);
      send(CMD_ACTIVATE, 3'h0, 14'h0);
      resp(1'b0, CMD_REFRESH);
      check(all_idle === 1'b0, "refresh interval");
      resp(1'b1, CMD_ACTIVATE);
      repeat (6) @(negedge clock);
      check(all_idle === 1'b1 && bank_idle === 8'hff, "refresh end");
   endtask
   task automatic t_refusals_and_all();
      send(CMD_WRITE, 3'h0, 14'h0);
      resp(1'b1, CMD_WRITE);
      send(CMD_ACTIVATE, 3'h6, 14'h0);
      resp(1'b0, CMD_ACTIVATE);
      send(CMD_REFRESH, 3'h0, 14'h0);
      resp(1'b1, CMD_REFRESH);
      send(CMD_PRECHARGE_ALL, 3'h0, 14'h0);
      resp(1'b0, CMD_PRECHARGE_ALL);
      repeat (3) @(negedge clock);
      check(bank_idle === 8'hff && all_idle === 1'b1, "precharge all");
   endtask
   task automatic t_mode_and_deselect();
      int hits;
      send(CMD_MODE_LOAD, 3'h2, 14'h1234);
      resp(1'b0, CMD_MODE_LOAD);
      check(mode_load === 1'b1 && mode_select === 3'h2 && mode_opcode === 14'h1234, "mode");
      repeat (3) @(negedge clock);
      send(CMD_DESELECT, 3'h0, 14'h0);
      go = 1'b0;
      hits = 0;
      repeat (6) begin
         @(negedge clock);
         if (mode_load !== 1'b0 || illegal !== 1'b0) hits++;
      end
      check(hits == 0 && cmd_code === CMD_MODE_LOAD, "deselect acted");
   endtask
   task automatic t_power();
      cke = 1'b0;
      repeat (6) @(negedge clock);
      check(power_down === 1'b1 && self_refresh === 1'b0, "power-down entry");
      cke = 1'b1;
      repeat (6) @(negedge clock);
      check(power_down === 1'b0, "power-down exit");
      send(CMD_ACTIVATE, 3'h1, 14'h0);
      resp(1'b0, CMD_ACTIVATE);
      send(CMD_WRITE_AP, 3'h1, 14'h0);
      resp(1'b0, CMD_WRITE_AP);
      term = 1'b1;
      repeat (4) @(negedge clock);
      check(termination_enable === 1'b1, "termination on");
      cke = 1'b0;
      send(CMD_SR_ENTRY, 3'h0, 14'h0);
      go = 1'b0;
      repeat (6) @(negedge clock);
      check(self_refresh === 1'b1 && termination_enable === 1'b0, "self refresh");
      cke = 1'b1;
      repeat (12) @(negedge clock);
      check(self_refresh === 1'b0 && termination_enable === 1'b1, "self refresh exit");
   endtask
   // ------------------------------------------------------------
   // Sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      repeat (12) @(negedge clock);
      check(bank_idle === 8'hff && all_idle === 1'b1 && cmd_code === CMD_DESELECT, "reset");
      resetn = 1'b1;
      repeat (3) @(negedge clock);
      t_open_read_close();
      t_auto_precharge();
      t_refresh();
      t_refusals_and_all();
      t_mode_and_deselect();
      t_power();
      give_verdict();
   end
   initial begin
      #100000;
      fail_count++;
      give_verdict();
   end
endmodule // sdcbf_command_fsm_tb_top
